/* src/fbcpu_pkg.sv */
/*
 * fbcpu_pkg: constants, opcodes, register map and carriers for the
 * four-bit core slice. Assumes a single 125 MHz clock domain and an
 * AHB-Lite master that issues single word transfers only.
 */
package fbcpu_pkg;

  localparam int PC_W      = 12;
  localparam int PAGE_W    = 5;
  localparam int LOW_W     = 7;
  localparam int OP_W      = 10;
  localparam int SP_W      = 3;
  localparam int STK_DEPTH = 8;
  localparam int PMEM_DEPTH = 4096;
  localparam int RAM_DEPTH = 256;

  localparam logic [SP_W-1:0]   SP_RESET   = 3'h7;
  localparam logic [SP_W:0]     DEPTH_MAX  = 4'h8;
  localparam logic [PAGE_W-1:0] PAGE_SCALL = 5'h02;
  localparam logic [3:0]        Y_DEC_SKIP = 4'hF;
  localparam logic [3:0]        Y_INC_SKIP = 4'h0;

  // single-word opcodes
  localparam logic [OP_W-1:0] OP_AND  = 10'h018;
  localparam logic [OP_W-1:0] OP_PDN  = 10'h002;
  localparam logic [OP_W-1:0] OP_IDIS = 10'h004;
  localparam logic [OP_W-1:0] OP_IEN  = 10'h005;
  localparam logic [OP_W-1:0] OP_YINC = 10'h013;
  localparam logic [OP_W-1:0] OP_YDEC = 10'h017;
  localparam logic [OP_W-1:0] OP_PARM = 10'h05B;
  localparam logic [OP_W-1:0] OP_RDP0 = 10'h260;
  localparam logic [OP_W-1:0] OP_RDP1 = 10'h261;
  localparam logic [OP_W-1:0] OP_OSC  = 10'h29B;
  localparam logic [OP_W-1:0] OP_WDA  = 10'h29C;
  // restart code chosen freely, not one of the decoded codes above
  localparam logic [OP_W-1:0] OP_WDR  = 10'h29E;
  // first words of two-word instructions, and opcode prefixes
  localparam logic [OP_W-1:0] OP_IBR  = 10'h010;
  localparam logic [OP_W-1:0] OP_ICAL = 10'h030;
  localparam logic [2:0]      PFX_BR  = 3'h3;
  localparam logic [2:0]      PFX_SC  = 3'h2;
  localparam logic [4:0]      PFX_LB  = 5'h07;
  localparam logic [4:0]      PFX_LC  = 5'h06;
  localparam logic [5:0]      PFX_LDA = 6'h07;
  localparam logic [1:0]      PFX_XY  = 2'h3;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_REGS  = 8'h08;
  localparam logic [7:0] ADDR_PROG  = 8'h0C;
  localparam logic [7:0] ADDR_RAM   = 8'h10;
  localparam logic [7:0] ADDR_STACK = 8'h14;
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int PROG_ADDR_LSB = 16;
  localparam int RAM_ADDR_LSB  = 8;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [2:0] {
    ST_HALT  = 3'h1,
    ST_EXEC  = 3'h2,
    ST_WORD2 = 3'h4
  } fbcpu_fsm_e;

  typedef struct packed {
    logic [8:0]      rsv;
    logic            stkOvf;
    logic            rcOsc;
    logic            pdown;
    logic            pdArm;
    logic            wdStop;
    logic            wdArm;
    logic            intAcc;
    logic            intEn;
    logic [SP_W-1:0] sp;
    logic [PC_W-1:0] pc;
  } fbcpu_stat_s;

  typedef struct packed {
    logic [15:0] rsv;
    logic        carry;
    logic [2:0]  d;
    logic [3:0]  y;
    logic [3:0]  x;
    logic [3:0]  a;
  } fbcpu_regs_s;

  typedef struct packed {
    logic            en;
    logic [SP_W-1:0] idx;
    logic [PC_W-1:0] data;
  } fbcpu_stkwr_s;

endpackage

/* src/fbcpu_ret_stack.sv */
/*
 * fbcpu_ret_stack: eight-entry return address store.
 * Assumes the core supplies the slot index; no reset on contents.
 */
`timescale 1ns/1ps
module fbcpu_ret_stack
  import fbcpu_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire fbcpu_stkwr_s    wr,
  input  wire logic [SP_W-1:0] rdIdx,
  output logic      [PC_W-1:0] rdData
);

  logic [PC_W-1:0] slot [STK_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr.en) begin
      slot[wr.idx] <= wr.data;
    end
  end

  assign rdData = slot[rdIdx];

endmodule

/* src/fbcpu_pin_sync.sv */
/*
 * fbcpu_pin_sync: three-stage pin synchroniser per bit; the output
 * moves only once stages two and three agree.
 * Assumes pins are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module fbcpu_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] levelOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } fbcpu_sync_s;

  fbcpu_sync_s  cur_ff;
  fbcpu_sync_s  nxt_cur;
  logic [W-1:0] agreed;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // s1 is read by s2 alone
      assign agreed[i] = (cur_ff.s2[i] == cur_ff.s3[i]) ? cur_ff.s3[i]
                                                        : cur_ff.lvl[i];
    end
  endgenerate

  always_comb begin
    nxt_cur     = cur_ff;
    nxt_cur.s1  = pinIn;
    nxt_cur.s2  = cur_ff.s1;
    nxt_cur.s3  = cur_ff.s2;
    nxt_cur.lvl = agreed;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign levelOut = cur_ff.lvl;

endmodule

/* src/fbcpu_core.sv */
/*
 * fbcpu_core: fetch, decode and execute for a slice of a four-bit
 * instruction set, with program and data memory loaded over AHB-Lite.
 * Assumes a zero-wait single-slave bus and asynchronous port pins.
 */
// Design decisions made here: the register offsets and register access over AHB-Lite.
// Contract
// - short branch loads seven-bit immediate, page unchanged.
// - long branch, two words, loads page and seven-bit address.
// - indirect branch/call low address is D[2:0] above accumulator.
// - short call pushes return, forces page two, loads immediate.
// - stack holds eight levels; deeper pushes overflow and flag it.
// - indirect call, two words, pushes return then jumps.
// - oscillator select switches main clock to RC oscillator.
// - Y decrement skips next instruction when result is fifteen.
// - Y increment skips next instruction when result wraps to zero.
// - stop arming lets a later restart stop the watchdog.
// - port reads copy synchronised port levels to accumulator.
// - immediate accumulator load; consecutive further loads skipped.
// - consecutive X/Y immediate loads after the first are skipped.
`timescale 1ns/1ps
module fbcpu_core
  import fbcpu_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic [3:0]  port0Pin,
  input  wire logic [3:0]  port1Pin,
  output logic             rcOscSel,
  output logic             powerDown,
  output logic             wdStopped,
  output logic             wdRestart,
  output logic             intAccept
);

  typedef struct packed {
    fbcpu_fsm_e      fsm;
    logic [PC_W-1:0] pc;
    logic [3:0]      a;
    logic [3:0]      x;
    logic [3:0]      y;
    logic [2:0]      d;
    logic            carry;
    logic [SP_W-1:0] sp;
    logic [SP_W:0]   depth;
    logic            stkOvf;
    logic            skip;
    logic            prevLdA;
    logic            prevLdXy;
    logic [OP_W-1:0] op1;
    logic            intEn;
    logic            intAcc;
    logic            wdArm;
    logic            wdStop;
    logic            wdRst;
    logic            pdArm;
    logic            pdown;
    logic            rcOsc;
    logic            run;
    logic            dphWr;
    logic [7:0]      dphAddr;
    logic [31:0]     rdata;
    logic            ready;
  } fbcpu_state_s;

  localparam fbcpu_state_s RST_STATE = '{
    fsm: ST_HALT, sp: SP_RESET, ready: 1'b1, default: '0};

  fbcpu_state_s    cur_ff;
  fbcpu_state_s    nxt_cur;
  fbcpu_stkwr_s    stkWr;
  fbcpu_stat_s     stat;
  fbcpu_regs_s     regsView;
  fbcpu_regs_s     regsIn;
  logic [OP_W-1:0] progMem [PMEM_DEPTH];
  logic [3:0]      dataRam [RAM_DEPTH];
  logic [OP_W-1:0] op;
  logic [3:0]      ramNib;
  logic [7:0]      portLvl;
  logic [PC_W-1:0] pcInc;
  logic [PC_W-1:0] stkTop;
  logic [PC_W-1:0] jumpPc;
  logic [3:0]      yDec;
  logic [3:0]      yInc;
  logic            isLdA;
  logic            isLdXy;
  logic            inRun;
  logic            skipNow;
  logic            exec;
  logic            pushReq;
  logic            addrPh;

  fbcpu_pin_sync #(
    .W (8)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .pinIn    ({port1Pin, port0Pin}),
    .levelOut (portLvl)
  );

  fbcpu_ret_stack u_stack (
    .sys_clk (sys_clk),
    .wr      (stkWr),
    .rdIdx   (cur_ff.sp),
    .rdData  (stkTop)
  );

  assign op     = progMem[cur_ff.pc];
  assign ramNib = dataRam[{cur_ff.x, cur_ff.y}];
  assign pcInc  = cur_ff.pc + 12'h001;
  assign yDec   = cur_ff.y - 4'h1;
  assign yInc   = cur_ff.y + 4'h1;
  assign isLdA  = (op[9:4] == PFX_LDA);
  assign isLdXy = (op[9:8] == PFX_XY);
  assign inRun  = (cur_ff.fsm == ST_EXEC) && cur_ff.run;
  assign skipNow = inRun && (cur_ff.skip || (isLdA && cur_ff.prevLdA)
                            || (isLdXy && cur_ff.prevLdXy));
  assign exec   = inRun && !skipNow;
  assign addrPh = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign regsIn = fbcpu_regs_s'(hwdata);

  always_comb begin
    stat         = '0;
    stat.stkOvf  = cur_ff.stkOvf;
    stat.rcOsc   = cur_ff.rcOsc;
    stat.pdown   = cur_ff.pdown;
    stat.pdArm   = cur_ff.pdArm;
    stat.wdStop  = cur_ff.wdStop;
    stat.wdArm   = cur_ff.wdArm;
    stat.intAcc  = cur_ff.intAcc;
    stat.intEn   = cur_ff.intEn;
    stat.sp      = cur_ff.sp;
    stat.pc      = cur_ff.pc;
    regsView     = '0;
    regsView.carry = cur_ff.carry;
    regsView.d   = cur_ff.d;
    regsView.y   = cur_ff.y;
    regsView.x   = cur_ff.x;
    regsView.a   = cur_ff.a;
  end

  always_comb begin
    nxt_cur       = cur_ff;
    stkWr         = '0;
    pushReq       = 1'b0;
    jumpPc        = pcInc;
    nxt_cur.wdRst = 1'b0;
    nxt_cur.ready = 1'b1;
    // data phase of a bus write
    if (cur_ff.dphWr) begin
      if (cur_ff.dphAddr == ADDR_CTRL) begin
        nxt_cur.run = hwdata[CTRL_RUN_BIT];
        if (hwdata[CTRL_WAKE_BIT]) begin
          nxt_cur.pdown = 1'b0;
        end
      end else if (cur_ff.dphAddr == ADDR_REGS) begin
        nxt_cur.a  = regsIn.a;
        nxt_cur.x  = regsIn.x;
        nxt_cur.y  = regsIn.y;
        nxt_cur.d  = regsIn.d;
        nxt_cur.carry = regsIn.carry;
      end
    end
    // address phase: capture write, prepare read data
    nxt_cur.dphWr   = addrPh && hwrite;
    nxt_cur.dphAddr = haddr[7:0];
    if (addrPh && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_CTRL:  nxt_cur.rdata = 32'(cur_ff.run);
        ADDR_STAT:  nxt_cur.rdata = 32'(stat);
        ADDR_REGS:  nxt_cur.rdata = 32'(regsView);
        ADDR_STACK: nxt_cur.rdata = 32'(stkTop);
        default:    nxt_cur.rdata = '0;
      endcase
    end
    unique case (cur_ff.fsm)
      ST_HALT: begin
        if (cur_ff.run && !cur_ff.pdown) begin
          nxt_cur.fsm = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (!cur_ff.run) begin
          nxt_cur.fsm = ST_HALT;
        end else begin
          nxt_cur.pc       = pcInc;
          nxt_cur.skip     = 1'b0;
          nxt_cur.prevLdA  = isLdA;
          nxt_cur.prevLdXy = isLdXy;
        end
        if (exec) begin
          nxt_cur.pdArm = 1'b0;
          if (op == OP_AND) begin
            nxt_cur.a = cur_ff.a & ramNib;
          end else if (op[9:7] == PFX_BR) begin
            nxt_cur.pc = {cur_ff.pc[PC_W-1:LOW_W], op[LOW_W-1:0]};
          end else if (op[9:7] == PFX_SC) begin
            pushReq    = 1'b1;
            nxt_cur.pc = {PAGE_SCALL, op[LOW_W-1:0]};
          end else if (op[9:5] == PFX_LB || op[9:5] == PFX_LC
                       || op == OP_IBR || op == OP_ICAL) begin
            nxt_cur.op1 = op;
            nxt_cur.fsm = ST_WORD2;
          end else if (op == OP_YDEC) begin
            nxt_cur.y    = yDec;
            nxt_cur.skip = (yDec == Y_DEC_SKIP);
          end else if (op == OP_YINC) begin
            nxt_cur.y    = yInc;
            nxt_cur.skip = (yInc == Y_INC_SKIP);
          end else if (op == OP_IEN) begin
            nxt_cur.intEn = 1'b1;
          end else if (op == OP_IDIS) begin
            nxt_cur.intEn = 1'b0;
          end else if (op == OP_WDA) begin
            nxt_cur.wdArm = 1'b1;
          end else if (op == OP_WDR) begin
            nxt_cur.wdRst = 1'b1;
            if (cur_ff.wdArm) begin
              nxt_cur.wdStop = 1'b1;
              nxt_cur.wdArm  = 1'b0;
            end
          end else if (op == OP_PARM) begin
            nxt_cur.pdArm = 1'b1;
          end else if (op == OP_PDN) begin
            if (cur_ff.pdArm) begin
              nxt_cur.pdown = 1'b1;
              nxt_cur.fsm   = ST_HALT;
            end
          end else if (op == OP_OSC) begin
            nxt_cur.rcOsc = 1'b1;
          end else if (op == OP_RDP0) begin
            nxt_cur.a = portLvl[3:0];
          end else if (op == OP_RDP1) begin
            nxt_cur.a = portLvl[7:4];
          end else if (isLdA) begin
            nxt_cur.a = op[3:0];
          end else if (isLdXy) begin
            nxt_cur.x = op[7:4];
            nxt_cur.y = op[3:0];
          end
        end
      end
      ST_WORD2: begin
        // second word is part of the instruction, never skipped
        nxt_cur.fsm     = ST_EXEC;
        nxt_cur.prevLdA  = 1'b0;
        nxt_cur.prevLdXy = 1'b0;
        if (cur_ff.op1[9:5] == PFX_LB || cur_ff.op1[9:5] == PFX_LC) begin
          jumpPc  = {cur_ff.op1[PAGE_W-1:0], op[LOW_W-1:0]};
          pushReq = (cur_ff.op1[9:5] == PFX_LC);
        end else begin
          jumpPc  = {op[6], op[3:0], cur_ff.d, cur_ff.a};
          pushReq = (cur_ff.op1 == OP_ICAL);
        end
        nxt_cur.pc = jumpPc;
      end
      default: nxt_cur.fsm = ST_HALT;
    endcase
    if (pushReq) begin
      nxt_cur.sp = cur_ff.sp + 3'h1;
      stkWr.en   = 1'b1;
      stkWr.idx  = cur_ff.sp + 3'h1;
      stkWr.data = pcInc;
      if (cur_ff.depth == DEPTH_MAX) begin
        nxt_cur.stkOvf = 1'b1;
      end else begin
        nxt_cur.depth = cur_ff.depth + 4'h1;
      end
    end
    // acceptance rises one cycle after the flag and falls in the same cycle as it
    nxt_cur.intAcc = nxt_cur.intEn && cur_ff.intEn;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= RST_STATE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // memories loaded only by software; no reset wanted on them
  always_ff @(posedge sys_clk) begin
    if (cur_ff.dphWr && cur_ff.dphAddr == ADDR_PROG) begin
      progMem[hwdata[PROG_ADDR_LSB +: PC_W]] <= hwdata[OP_W-1:0];
    end
    if (cur_ff.dphWr && cur_ff.dphAddr == ADDR_RAM) begin
      dataRam[hwdata[RAM_ADDR_LSB +: 8]] <= hwdata[3:0];
    end
  end

  assign hreadyout = cur_ff.ready;
  assign hrdata    = cur_ff.rdata;
  assign hresp     = HRESP_OKAY;
  assign rcOscSel  = cur_ff.rcOsc;
  assign powerDown = cur_ff.pdown;
  assign wdStopped = cur_ff.wdStop;
  assign wdRestart = cur_ff.wdRst;
  assign intAccept = cur_ff.intAcc;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_twoWordFirst(logic [4:0] pfx);
    exec && op[9:5] == pfx;
  endsequence

  property p_and;
    exec && op == OP_AND |=> cur_ff.a == $past(cur_ff.a & ramNib);
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");

  property p_branch;
    exec && op[9:7] == PFX_BR |=>
      cur_ff.pc == {$past(cur_ff.pc[PC_W-1:LOW_W]), $past(op[6:0])};
  endproperty
  a_branch: assert property (p_branch) else $error("branch pc wrong");

  property p_longBranch;
    s_twoWordFirst(PFX_LB) |=> cur_ff.fsm == ST_WORD2 ##1
      cur_ff.pc[PC_W-1:LOW_W] == $past(op[4:0], 2);
  endproperty
  a_longBranch: assert property (p_longBranch) else $error("long br");

  property p_shortCall;
    exec && op[9:7] == PFX_SC |=> cur_ff.pc[PC_W-1:LOW_W] == PAGE_SCALL
      && cur_ff.sp == $past(cur_ff.sp) + 3'h1 && stkTop == $past(pcInc);
  endproperty
  a_shortCall: assert property (p_shortCall) else $error("call bad");

  property p_yDec;
    exec && op == OP_YDEC && cur_ff.y == 4'h0 |=> cur_ff.skip ##1
      cur_ff.a == $past(cur_ff.a);
  endproperty
  a_yDec: assert property (p_yDec) else $error("dec skip missing");

  property p_yInc;
    exec && op == OP_YINC |=> cur_ff.skip == (cur_ff.y == 4'h0);
  endproperty
  a_yInc: assert property (p_yInc) else $error("inc skip wrong");

  property p_intEn;
    exec && op == OP_IEN && !cur_ff.intEn |=> cur_ff.intEn && !intAccept
      ##1 (intAccept || !cur_ff.intEn);
  endproperty
  a_intEn: assert property (p_intEn) else $error("enable timing");

  property p_pdown;
    exec && op == OP_PDN && !cur_ff.pdArm |=> !powerDown;
  endproperty
  a_pdown: assert property (p_pdown) else $error("unarmed power-down");

  property p_ldaRun;
    inRun && isLdA && cur_ff.prevLdA && !cur_ff.skip |=>
      cur_ff.a == $past(cur_ff.a);
  endproperty
  a_ldaRun: assert property (p_ldaRun) else $error("load not skipped");

  property p_skip;
    skipNow |=> cur_ff.a == $past(cur_ff.a) && cur_ff.y == $past(cur_ff.y)
      && cur_ff.sp == $past(cur_ff.sp);
  endproperty
  a_skip: assert property (p_skip) else $error("skip changed state");

endmodule

/* test/fbcpu_tb.sv */
/*
 * fbcpu_tb: self-checking bench for the four-bit core slice.
 * Assumes a zero-wait AHB-Lite slave; programs and RAM are loaded
 * over the bus, and each program ends in a branch-to-self loop.
 */
`timescale 1ns/1ps
module tb;
  import fbcpu_pkg::*;

  logic        sysClk;
  logic        rstn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  port0Pin;
  logic [3:0]  port1Pin;
  logic        rcOscSel;
  logic        powerDown;
  logic        wdStopped;
  logic        wdRestart;
  logic        intAccept;
  int          badCount;
  int          checksDone;
  int          cyc;
  int          wdPulses;

  fbcpu_core u_dut (
    .sys_clk   (sysClk),
    .rstn      (rstn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .port0Pin  (port0Pin),
    .port1Pin  (port1Pin),
    .rcOscSel  (rcOscSel),
    .powerDown (powerDown),
    .wdStopped (wdStopped),
    .wdRestart (wdRestart),
    .intAccept (intAccept)
  );

  initial begin
    sysClk = 1'b0;
    forever #4 sysClk = ~sysClk;
  end

  task automatic summarize();
    if (badCount == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // a hang anywhere counts as a mismatch
  always @(posedge sysClk) begin
    cyc++;
    // restart output stands one cycle; count each pulse
    if (wdRestart === 1'b1) begin
      wdPulses++;
    end
    if (cyc == 20000) begin
      badCount++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sysClk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic pw(input logic [11:0] a, input logic [9:0] op);
    ahb(1'b1, ADDR_PROG, {4'h0, a, 6'h0, op});
  endtask

  task automatic rst();
    rstn <= 1'b0;
    repeat (2) @(posedge sysClk);
    rstn <= 1'b1;
  endtask

  // loops are waited out; 40 cycles covers every program below
  task automatic run();
    ahb(1'b1, ADDR_CTRL, 32'h1);
    repeat (40) @(posedge sysClk);
  endtask

  function automatic logic [9:0] ldA(input logic [3:0] n);
    return {PFX_LDA, n};
  endfunction

  function automatic logic [9:0] br(input logic [6:0] a);
    return {PFX_BR, a};
  endfunction

  function automatic logic [9:0] sc(input logic [6:0] a);
    return {PFX_SC, a};
  endfunction

  function automatic logic [9:0] w2(input logic [6:0] a);
    return {3'h4, a};
  endfunction

  function automatic logic [9:0] pg(input logic [4:0] p);
    return {3'h4, p[4], 2'h0, p[3:0]};
  endfunction

  task automatic testBasic();
    rst();
    ahb(1'b0, ADDR_REGS, 32'h0);
    chk("regsReset", rd, 32'h0);
    ahb(1'b0, ADDR_STAT, 32'h0);
    chk("statReset", rd, 32'h7000);
    ahb(1'b0, 8'h18, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b1, ADDR_RAM, 32'h1006);
    pw(12'h000, {PFX_XY, 8'h10});
    pw(12'h001, {PFX_XY, 8'h22});
    pw(12'h002, ldA(4'hD));
    pw(12'h003, ldA(4'h2));
    pw(12'h004, OP_AND);
    pw(12'h005, OP_YDEC);
    pw(12'h006, ldA(4'h1));
    pw(12'h007, OP_YINC);
    pw(12'h008, ldA(4'h2));
    pw(12'h009, OP_IEN);
    pw(12'h00A, OP_IDIS);
    pw(12'h00B, br(7'h0B));
    // carry set beforehand must survive the and
    ahb(1'b1, ADDR_REGS, 32'h8000);
    run();
    ahb(1'b0, ADDR_REGS, 32'h0);
    chk("regsAndSkip", rd, 32'h8014);
    ahb(1'b0, ADDR_STAT, 32'h0);
    chk("statBasic", {16'h0, rd[15:0]}, 32'h700B);
  endtask

  task automatic testCalls();
    rst();
    ahb(1'b1, ADDR_REGS, 32'h3005);
    pw(12'h000, sc(7'h10));
    pw(12'h110, {PFX_LC, 5'h03});
    pw(12'h111, w2(7'h20));
    pw(12'h1A0, OP_ICAL);
    pw(12'h1A1, pg(5'h04));
    pw(12'h235, {PFX_LB, 5'h05});
    pw(12'h236, w2(7'h11));
    pw(12'h291, br(7'h11));
    run();
    ahb(1'b0, ADDR_STAT, 32'h0);
    chk("callStat", {9'h0, rd[22:0]}, 32'h2291);
    ahb(1'b0, ADDR_STACK, 32'h0);
    chk("callReturn", rd, 32'h01A2);
    ahb(1'b0, ADDR_REGS, 32'h0);
    chk("callRegs", rd, 32'h3005);
  endtask

  task automatic testMisc();
    rst();
    port0Pin <= 4'hA;
    port1Pin <= 4'h5;
    pw(12'h000, OP_IEN);
    pw(12'h001, OP_OSC);
    pw(12'h002, OP_WDA);
    pw(12'h003, OP_WDR);
    pw(12'h004, OP_PDN);
    pw(12'h005, OP_RDP0);
    pw(12'h006, OP_IBR);
    pw(12'h007, pg(5'h01));
    pw(12'h08A, OP_RDP1);
    pw(12'h08B, OP_PARM);
    pw(12'h08C, OP_PDN);
    pw(12'h08D, br(7'h0D));
    run();
    chk("powerDown", {31'h0, powerDown}, 32'h1);
    chk("rcOscSel", {31'h0, rcOscSel}, 32'h1);
    chk("wdStopped", {31'h0, wdStopped}, 32'h1);
    chk("wdRestart", wdPulses, 32'h1);
    chk("intAccept", {31'h0, intAccept}, 32'h1);
    ahb(1'b0, ADDR_REGS, 32'h0);
    chk("portRead", {28'h0, rd[3:0]}, 32'h5);
    ahb(1'b1, ADDR_CTRL, 32'h3);
    repeat (10) @(posedge sysClk);
    chk("wake", {31'h0, powerDown}, 32'h0);
    ahb(1'b0, ADDR_STAT, 32'h0);
    chk("wakePc", {20'h0, rd[11:0]}, 32'h08D);
  endtask

  task automatic testOverflow();
    rst();
    pw(12'h000, sc(7'h00));
    // nine nested calls, one past the stack depth
    for (int i = 0; i < 8; i++) begin
      pw(12'h100 + 12'(i), sc(7'(i + 1)));
    end
    pw(12'h108, br(7'h08));
    run();
    ahb(1'b0, ADDR_STAT, 32'h0);
    chk("overflow", {21'h0, rd[22:12]}, 32'h400);
  endtask

  initial begin
    rstn     = 1'b0;
    hsel     = 1'b0;
    hwrite   = 1'b0;
    haddr    = 32'h0;
    hwdata   = 32'h0;
    htrans   = 2'h0;
    hsize    = 3'h2;
    port0Pin = 4'h0;
    port1Pin = 4'h0;
    badCount = 0;
    checksDone = 0;
    cyc      = 0;
    wdPulses = 0;
    testBasic();
    testCalls();
    testMisc();
    testOverflow();
    summarize();
  end
endmodule
